//--- rtl/rtc_evt_pkg.sv
// Constants for the event-status and day-alarm register block
package rtc_evt_pkg;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_BACKUP_DAY   = 8'h0d;
  localparam int         BIT_IRQ_FLAG     = 7;
  localparam int         BIT_PERIODIC     = 6;
  localparam int         BIT_ALARM        = 5;
  localparam int         BIT_UPDATE       = 4;
  localparam int         BIT_BACKUP_OK    = 7;
  localparam int         DAY_ALARM_W      = 6;
  localparam logic [7:0] EVENT_STATUS_RST = 8'h00;
  localparam logic [5:0] DAY_ALARM_OFF    = 6'h00;
endpackage

//--- rtl/rtc_pin_sync.sv
// Three-stage pin synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
module rtc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          sync_o[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          sync_o[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule

//--- rtl/rtc_event_status.sv
// Event flags, interrupt request and day-of-month alarm register logic
`timescale 1ns/1ps
module rtc_event_status (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Register access port (decoded address, one-cycle strobes)
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Timekeeping events and settings
  input  wire logic       update_done_i,
  input  wire logic       alarm_match_i,
  input  wire logic       periodic_tick_i,
  input  wire logic [5:0] current_day_i,
  input  wire logic       alarm_irq_enable_i,
  input  wire logic       periodic_irq_enable_i,
  input  wire logic       update_irq_enable_i,
  input  wire logic       update_transfer_inhibit_i,
  output logic            update_irq_enable_clr_o,
  // Backup source status pin
  input  wire logic       backup_valid_i,
  // Interrupt pin
  output logic            irq_n_o
);
  logic       rst_s1;
  logic       rst_n;
  logic       backup_valid;
  logic       update_event_flag;
  logic       alarm_event_flag;
  logic       periodic_event_flag;
  logic       irq_request_flag;
  logic [5:0] day_of_month_alarm;
  logic       status_rd;
  logic       alarm_event;
  logic       update_en_eff;
  logic       any_enabled;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  rtc_pin_sync #(
    .WIDTH (1)
  ) u_backup_sync (
    .clk_i   (clk_i),
    .rst_n   (rst_n),
    .async_i (backup_valid_i),
    .sync_o  (backup_valid)
  );

  assign status_rd = reg_rd_i && (reg_addr_i == rtc_evt_pkg::OFS_EVENT_STATUS);

  assign alarm_event = alarm_match_i &&
                       ((day_of_month_alarm == rtc_evt_pkg::DAY_ALARM_OFF) || (current_day_i == day_of_month_alarm));

  assign update_en_eff           = update_irq_enable_i && !update_transfer_inhibit_i;
  assign update_irq_enable_clr_o = update_transfer_inhibit_i;

  assign any_enabled = (alarm_irq_enable_i && (alarm_event_flag || alarm_event)) ||
                       (periodic_irq_enable_i && (periodic_event_flag || periodic_tick_i)) ||
                       (update_en_eff && (update_event_flag || update_done_i));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      update_event_flag   <= 1'b0;
      alarm_event_flag    <= 1'b0;
      periodic_event_flag <= 1'b0;
    end else begin
      update_event_flag   <= update_done_i || (update_event_flag && !status_rd);
      alarm_event_flag    <= alarm_event || (alarm_event_flag && !status_rd);
      periodic_event_flag <= periodic_tick_i || (periodic_event_flag && !status_rd);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_request_flag <= 1'b0;
    end else if (status_rd) begin
      irq_request_flag <= (alarm_irq_enable_i && alarm_event) || (periodic_irq_enable_i && periodic_tick_i) ||
                          (update_en_eff && update_done_i);
    end else begin
      irq_request_flag <= irq_request_flag || any_enabled;
    end
  end

  // no reset term; host write of day alarm
  always_ff @(posedge clk_i) begin
    if (reg_wr_i && (reg_addr_i == rtc_evt_pkg::OFS_BACKUP_DAY)) begin
      day_of_month_alarm <= reg_wdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        rtc_evt_pkg::OFS_EVENT_STATUS:
          reg_rdata_o <= {irq_request_flag, periodic_event_flag, alarm_event_flag, update_event_flag, 4'h0};
        rtc_evt_pkg::OFS_BACKUP_DAY:
          reg_rdata_o <= {backup_valid, 1'b0, day_of_month_alarm};
        default:
          reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign irq_n_o = !irq_request_flag;

  // Assertions
  chk_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n)
    status_rd && !update_done_i |=> !update_event_flag)
    else $error("update flag not cleared by status read");
  chk_update_sets: assert property (@(posedge clk_i) disable iff (!rst_n)
    update_done_i |=> update_event_flag)
    else $error("update flag not set");
  chk_periodic_sets: assert property (@(posedge clk_i) disable iff (!rst_n)
    periodic_tick_i |=> periodic_event_flag)
    else $error("periodic flag not set");
  chk_alarm_day_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
    alarm_match_i && !alarm_event_flag && !status_rd && day_of_month_alarm != 6'h00 &&
    current_day_i != day_of_month_alarm |=> !alarm_event_flag)
    else $error("alarm flag set on day mismatch");
  chk_irq_enable: assert property (@(posedge clk_i) disable iff (!rst_n)
    alarm_event_flag && alarm_irq_enable_i && !status_rd |=> irq_request_flag)
    else $error("request flag missing for enabled alarm");
  chk_inhibit_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
    status_rd ##1 (!irq_request_flag && update_transfer_inhibit_i && !alarm_irq_enable_i &&
    !periodic_irq_enable_i && !status_rd) |=> !irq_request_flag)
    else $error("update event raised request under inhibit");
  chk_status_zero_bits: assert property (@(posedge clk_i) disable iff (!rst_n)
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h0c |-> reg_rdata_o[3:0] == 4'h0)
    else $error("status low bits not zero");
  chk_bit6_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h0d |-> reg_rdata_o[6] == 1'b0 &&
    reg_rdata_o[7] == $past(backup_valid))
    else $error("second register bit 6 or 7 wrong");
  chk_irq_pin: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(irq_request_flag) |-> !irq_n_o)
    else $error("interrupt pin not asserted");
endmodule

//--- tb/rtc_host_model.sv
// Host model issuing one-cycle register read and write strobes
`timescale 1ns/1ps
module rtc_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] reg_addr_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released data lines show the inverse of the last value
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule

//--- tb/rtc_event_status_and_day_alarm_bench.sv
// Self-checking bench for the event status and day alarm block
`timescale 1ns/1ps
module rtc_event_status_and_day_alarm_bench;
  logic       clk_i;
  logic       resetn_i;
  logic [7:0] addr;
  logic       rd;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] rdata;
  logic [2:0] ev;
  logic [2:0] en;
  logic [5:0] day;
  logic       inh;
  logic       bkp;
  logic       clr;
  logic       irq_n;
  logic [7:0] v;
  int         n_errors;
  int         n_checks;
  int         cyc;
  rtc_host_model u_rtc_host_model (.clk_i(clk_i), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_wdata_o(wd), .reg_rdata_i(rdata));
  rtc_event_status u_rtc_event_status (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .update_done_i(ev[0]),
    .alarm_match_i(ev[1]), .periodic_tick_i(ev[2]), .current_day_i(day), .alarm_irq_enable_i(en[1]),
    .periodic_irq_enable_i(en[2]), .update_irq_enable_i(en[0]), .update_transfer_inhibit_i(inh),
    .update_irq_enable_clr_o(clr), .backup_valid_i(bkp), .irq_n_o(irq_n));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic pulse(int i);
    @(posedge clk_i);
    ev <= 3'b001 << i;
    @(posedge clk_i);
    ev <= 3'b000;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic rst_dut();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_events();
    u_rtc_host_model.wr(8'h0c, 8'hff);
    u_rtc_host_model.rd(8'h0c, v); chk("status_ro", v, 8'h00);
    u_rtc_host_model.wr(8'h0d, 8'h00);
    for (int i = 0; i < 3; i++) for (int e = 0; e < 2; e++) begin
      en <= {3{e[0]}};
      pulse(i);
      chk("irq_pin", irq_n, !e[0]);
      u_rtc_host_model.rd(8'h0c, v); chk("status", v, (8'h10 << i) | (e[0] ? 8'h80 : 8'h00));
      u_rtc_host_model.rd(8'h0c, v); chk("status_clr", v, 8'h00);
      chk("irq_pin_clr", irq_n, 1'b1);
    end
  endtask
  task automatic t_day();
    u_rtc_host_model.wr(8'h0d, 8'hc5);
    u_rtc_host_model.rd(8'h0d, v); chk("day_reg", v, 8'h85);
    day <= 6'h04;
    pulse(1);
    u_rtc_host_model.rd(8'h0c, v); chk("day_miss", v, 8'h00);
    day <= 6'h05;
    pulse(1);
    u_rtc_host_model.rd(8'h0c, v); chk("day_hit", v, 8'ha0);
    bkp <= 1'b0;
    repeat (6) @(posedge clk_i);
    u_rtc_host_model.rd(8'h0d, v); chk("backup_bad", v, 8'h05);
    rst_dut();
    u_rtc_host_model.rd(8'h0d, v); chk("day_kept", v, 8'h05);
  endtask
  task automatic t_inhibit();
    inh <= 1'b1;
    @(negedge clk_i);
    chk("en_clear", clr, 1'b1);
    pulse(0);
    u_rtc_host_model.rd(8'h0c, v); chk("inh_status", v, 8'h10);
    inh <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    {n_errors, n_checks, cyc} = 0;
    {resetn_i, ev, en, inh} = 0;
    day = 6'h01;
    bkp = 1'b1;
    rst_dut();
    u_rtc_host_model.rd(8'h0c, v); chk("rst_status", v, 8'h00);
    chk("rst_irq", irq_n, 1'b1);
    t_events();
    t_day();
    t_inhibit();
    end_sim();
  end
endmodule
